// File: logic/wdg_pkg.sv
package wdg_pkg;
  // ----------------------------------------------------------------
  // register byte offsets on the bus
  // ----------------------------------------------------------------
  localparam logic [11:0] CAUSE_OFS = 12'h000; // reset_cause_flags
  localparam logic [11:0] CTRL_OFS = 12'h004;  // watchdog_control
  localparam logic [11:0] IRQ_STAT_OFS = 12'h008; // sticky event bits
  localparam logic [11:0] IRQ_MASK_OFS = 12'h00C; // event mask

  // ----------------------------------------------------------------
  // reset_cause_flags field positions
  // ----------------------------------------------------------------
  localparam int POWERON_BIT = 0;
  localparam int PIN_BIT = 1;
  localparam int BROWNOUT_BIT = 2;
  localparam int DOG_BIT = 3;
  localparam int SCAN_BIT = 4;
  localparam int CAUSE_W = 5;
  localparam logic [4:0] CAUSE_RST = 5'h01; // power-on flag only

  // ----------------------------------------------------------------
  // watchdog_control field positions
  // ----------------------------------------------------------------
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 3;
  localparam int ENABLE_BIT = 3;
  localparam int WINDOW_BIT = 4;
  localparam logic [2:0] SEL_RST = 3'h0;

  // ----------------------------------------------------------------
  // interrupt event bits
  // ----------------------------------------------------------------
  localparam int EV_TIMEOUT = 0; // watchdog expired
  localparam int EV_CAUSE = 1;   // pin, brownout, scan or watchdog cause recorded
  localparam int EV_W = 2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int WINDOW_CYCLES = 4; // change window length, clocks
  localparam logic [2:0] WINDOW_LAST = 3'h4;
  localparam int BASE_TICKS = 16384; // oscillator ticks at code 000
  localparam int CNT_W = 22;         // holds 2,048K ticks
endpackage : wdg_pkg

// File: logic/wdg_top.sv
`timescale 1ns/1ns
`default_nettype none
module wdg_top #(
  parameter int BASE_TICKS = wdg_pkg::BASE_TICKS // shorten in simulation
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic SRST, // power-on reset, synchronous
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // reset sources and watchdog inputs
  input wire logic PIN_RESET_EVENT,
  input wire logic BROWNOUT_EVENT,
  input wire logic SCAN_RESET_EVENT,
  input wire logic CHIP_RESET,
  input wire logic WATCHDOG_KICK,
  input wire logic OSC_TICK,
  input wire logic ALWAYS_ON_FUSE,
  // outputs
  output logic DOG_RESET,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic setup; // first phase of a transfer
  logic wr_acc; // write taking effect this edge
  logic hit_cause, hit_ctrl, hit_stat, hit_mask;
  assign setup = PSEL & ~PENABLE;
  assign wr_acc = PSEL & PENABLE & PWRITE;
  assign hit_cause = PADDR == wdg_pkg::CAUSE_OFS;
  assign hit_ctrl = PADDR == wdg_pkg::CTRL_OFS;
  assign hit_stat = PADDR == wdg_pkg::IRQ_STAT_OFS;
  assign hit_mask = PADDR == wdg_pkg::IRQ_MASK_OFS;
  assign PREADY = 1'b1; // no wait states: read data ready after setup

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [wdg_pkg::CAUSE_W-1:0] cause_reg; // reset cause flags
  logic enable_reg; // watchdog_enable
  logic [wdg_pkg::SEL_W-1:0] sel_reg; // timeout select
  logic window_reg; // change_window_enable
  logic [2:0] window_cnt_reg; // clocks since window opened
  logic [wdg_pkg::CNT_W-1:0] count_reg; // oscillator ticks counted
  logic [wdg_pkg::EV_W-1:0] stat_reg; // sticky events
  logic [wdg_pkg::EV_W-1:0] mask_reg; // event mask
  logic tick_s1_reg, tick_s2_reg, tick_s3_reg; // tick synchroniser
  logic dog_reg; // reset pulse
  logic slverr_reg;

  logic enable_eff; // enable as seen by the counter and by reads
  logic tick; // one clock per rising oscillator edge
  logic expire; // counter reached its end
  logic [wdg_pkg::CNT_W-1:0] terminal;
  logic ctrl_wr;
  logic [wdg_pkg::EV_W-1:0] events;

  assign enable_eff = enable_reg | ALWAYS_ON_FUSE;
  assign ctrl_wr = wr_acc & hit_ctrl;

  // ----------------------------------------------------------------
  // oscillator tick crossing
  // ----------------------------------------------------------------
  // first stage is read only by the second; edge taken after
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      tick_s1_reg <= 1'b0;
      tick_s2_reg <= 1'b0;
      tick_s3_reg <= 1'b0;
    end else begin
      tick_s1_reg <= OSC_TICK;
      tick_s2_reg <= tick_s1_reg;
      tick_s3_reg <= tick_s2_reg;
    end
  end
  assign tick = tick_s2_reg & ~tick_s3_reg;

  // ----------------------------------------------------------------
  // change window
  // ----------------------------------------------------------------
  // opened by writing window and enable both to one
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      window_reg <= 1'b0;
      window_cnt_reg <= 3'h0;
    end else if (ctrl_wr && PWDATA[wdg_pkg::WINDOW_BIT]
                 && PWDATA[wdg_pkg::ENABLE_BIT]) begin
      window_reg <= 1'b1; // (re)open
      window_cnt_reg <= 3'h1;
    end else if (ctrl_wr) begin
      window_reg <= 1'b0; // second write of the sequence closes it
      window_cnt_reg <= 3'h0;
    end else if (window_reg && window_cnt_reg == wdg_pkg::WINDOW_LAST) begin
      window_reg <= 1'b0;
      window_cnt_reg <= 3'h0;
    end else if (window_reg) begin
      window_cnt_reg <= window_cnt_reg + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // enable and timeout select
  // ----------------------------------------------------------------
  // a write that reopens the window still sets enable (written one)
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      enable_reg <= 1'b0;
      sel_reg <= wdg_pkg::SEL_RST;
    end else if (ctrl_wr) begin
      if (PWDATA[wdg_pkg::ENABLE_BIT]) begin
        enable_reg <= 1'b1;
      end else if (window_reg) begin
        enable_reg <= 1'b0;
      end
      if (window_reg) begin
        sel_reg <= PWDATA[wdg_pkg::SEL_LSB +: wdg_pkg::SEL_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // watchdog counter
  // ----------------------------------------------------------------
  // 16K ticks doubled per select step
  assign terminal = wdg_pkg::CNT_W'((BASE_TICKS << sel_reg) - 1);
  assign expire = enable_eff & tick & (count_reg >= terminal);

  always_ff @(posedge MCLK) begin
    if (SRST || CHIP_RESET || WATCHDOG_KICK || !enable_eff) begin
      count_reg <= '0;
    end else if (expire) begin
      count_reg <= '0;
    end else if (tick) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  // one clock wide, registered one clock after the expiring tick
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      dog_reg <= 1'b0;
    end else begin
      dog_reg <= expire;
    end
  end
  assign DOG_RESET = dog_reg;

  // ----------------------------------------------------------------
  // reset cause flags
  // ----------------------------------------------------------------
  // set wins over a clearing write; writing one leaves a flag alone
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      cause_reg <= wdg_pkg::CAUSE_RST;
    end else begin
      for (int i = 0; i < wdg_pkg::CAUSE_W; i++) begin
        if (wr_acc && hit_cause && !PWDATA[i]) begin
          cause_reg[i] <= 1'b0;
        end
      end
      if (PIN_RESET_EVENT) cause_reg[wdg_pkg::PIN_BIT] <= 1'b1;
      if (BROWNOUT_EVENT) cause_reg[wdg_pkg::BROWNOUT_BIT] <= 1'b1;
      if (dog_reg) cause_reg[wdg_pkg::DOG_BIT] <= 1'b1;
      if (SCAN_RESET_EVENT) cause_reg[wdg_pkg::SCAN_BIT] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  always_comb begin
    events = '0;
    events[wdg_pkg::EV_TIMEOUT] = dog_reg;
    events[wdg_pkg::EV_CAUSE] = PIN_RESET_EVENT | BROWNOUT_EVENT
                                | SCAN_RESET_EVENT | dog_reg;
  end

  // write one to clear; a new event in the same clock wins
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      stat_reg <= '0;
    end else if (wr_acc && hit_stat) begin
      stat_reg <= (stat_reg & ~PWDATA[wdg_pkg::EV_W-1:0]) | events;
    end else begin
      stat_reg <= stat_reg | events;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      mask_reg <= '0;
    end else if (wr_acc && hit_mask) begin
      mask_reg <= PWDATA[wdg_pkg::EV_W-1:0];
    end
  end
  assign IRQ = |(stat_reg & mask_reg);

  // ----------------------------------------------------------------
  // read data and error, captured in the setup phase
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      PRDATA <= 32'h0000_0000;
      slverr_reg <= 1'b0;
    end else if (setup) begin
      slverr_reg <= ~(hit_cause | hit_ctrl | hit_stat | hit_mask);
      PRDATA <= 32'h0000_0000; // upper bits and reserved bits zero
      if (hit_cause) begin
        PRDATA[wdg_pkg::CAUSE_W-1:0] <= cause_reg;
      end else if (hit_ctrl) begin
        PRDATA[wdg_pkg::WINDOW_BIT] <= window_reg;
        PRDATA[wdg_pkg::ENABLE_BIT] <= enable_eff;
        PRDATA[wdg_pkg::SEL_LSB +: wdg_pkg::SEL_W] <= sel_reg;
      end else if (hit_stat) begin
        PRDATA[wdg_pkg::EV_W-1:0] <= stat_reg;
      end else if (hit_mask) begin
        PRDATA[wdg_pkg::EV_W-1:0] <= mask_reg;
      end
    end
  end
  assign PSLVERR = slverr_reg & PSEL & PENABLE;

endmodule : wdg_top
`default_nettype wire

// File: tb/wdg_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module wdg_monitor #(
  parameter int BASE_TICKS = 4
) (
  // clock and bus
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // watchdog side
  input wire logic CHIP_RESET,
  input wire logic ALWAYS_ON_FUSE,
  input wire logic DOG_RESET,
  input wire logic IRQ
);
  // ------------------------------------------------------------
  // bus and watchdog checks
  // ------------------------------------------------------------
  default clocking @(posedge MCLK); endclocking
  default disable iff (SRST);
  // access phase of any transfer
  wire logic acc = PSEL && PENABLE;
  // four ticks of two clocks at least keep pulses apart
  a_dog_single: assert property (DOG_RESET |=> !DOG_RESET [*7])
    else $error("watchdog reset pulse too long or too close");
  a_rsv_zero: assert property (acc && !PWRITE && PADDR == wdg_pkg::CTRL_OFS |->
    PRDATA[7:5] == 3'h0) else $error("control reserved bits not zero");
  a_fuse_enable: assert property (acc && !PWRITE && PADDR == wdg_pkg::CTRL_OFS
    && ALWAYS_ON_FUSE |-> PRDATA[3]) else $error("fuse set but enable reads zero");
  a_chip_restart: assert property (CHIP_RESET [*2] |=> !DOG_RESET)
    else $error("watchdog fired right after chip reset");
  a_err_unmapped: assert property (acc && PADDR > wdg_pkg::IRQ_MASK_OFS |-> PSLVERR)
    else $error("unmapped access without error");
  a_err_access: assert property (PSLVERR |-> acc)
    else $error("error response outside access phase");
  a_ready_access: assert property (acc |-> PREADY)
    else $error("access phase not completed");
  a_mask_off_irq: assert property (acc && PWRITE && PADDR == wdg_pkg::IRQ_MASK_OFS
    && PWDATA[1:0] == 2'h0 |=> !IRQ) else $error("interrupt high with all masked");
endmodule : wdg_monitor
bind wdg_top wdg_monitor #(.BASE_TICKS(BASE_TICKS)) u_mon (
  .MCLK(MCLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .CHIP_RESET(CHIP_RESET), .ALWAYS_ON_FUSE(ALWAYS_ON_FUSE),
  .DOG_RESET(DOG_RESET), .IRQ(IRQ)
);
`default_nettype wire

// File: tb/wdg_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module wdg_top_bench;
  // ------------------------------------------------------------
  // stimulus, design and helpers
  // ------------------------------------------------------------
  localparam logic [11:0] CA = wdg_pkg::CAUSE_OFS;
  localparam logic [11:0] WA = wdg_pkg::CTRL_OFS;
  logic MCLK = 1'h0;
  logic SRST = 1'h1, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic PREADY, PSLVERR, DOG_RESET, IRQ, err;
  logic PIN_RESET_EVENT = 1'h0, BROWNOUT_EVENT = 1'h0, SCAN_RESET_EVENT = 1'h0;
  logic CHIP_RESET = 1'h0, WATCHDOG_KICK = 1'h0, OSC_TICK = 1'h0, ALWAYS_ON_FUSE = 1'h0;
  int error_cnt = 0, n_compared = 0;
  // one bus step: write flag, address, data or expected read, idle after
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [3:0] n;} wdg_row_s;
  wdg_row_s rows [14] = '{'{1'h0, CA, 32'h01, 4'h1}, '{1'h0, WA, 32'h00, 4'h1},
    '{1'h1, WA, 32'h08, 4'h1}, '{1'h1, WA, 32'h05, 4'h1}, '{1'h0, WA, 32'h08, 4'h1},
    '{1'h1, WA, 32'h18, 4'h0}, '{1'h0, WA, 32'h18, 4'h6}, '{1'h1, WA, 32'h00, 4'h1},
    '{1'h0, WA, 32'h08, 4'h1}, '{1'h1, WA, 32'h18, 4'h0}, '{1'h1, WA, 32'h05, 4'h1},
    '{1'h0, WA, 32'h05, 4'h1}, '{1'h1, WA, 32'hE8, 4'h1}, '{1'h0, WA, 32'h0D, 4'h1}};
  always #50 MCLK = ~MCLK;
  wdg_top #(.BASE_TICKS(4)) uut (.MCLK(MCLK), .SRST(SRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PIN_RESET_EVENT(PIN_RESET_EVENT), .BROWNOUT_EVENT(BROWNOUT_EVENT),
    .SCAN_RESET_EVENT(SCAN_RESET_EVENT), .CHIP_RESET(CHIP_RESET),
    .WATCHDOG_KICK(WATCHDOG_KICK), .OSC_TICK(OSC_TICK),
    .ALWAYS_ON_FUSE(ALWAYS_ON_FUSE), .DOG_RESET(DOG_RESET), .IRQ(IRQ));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  // setup then access; held until ready, request left up for back to back
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    PSEL <= 1'h1;
    PENABLE <= 1'h0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'h1;
    k = 0;
    do begin
      @(posedge MCLK);
      k++;
    end while (PREADY !== 1'h1 && k < 20);
    if (PREADY !== 1'h1) begin
      error_cnt++;
      stop_test();
    end
    rd = PRDATA;
    err = PSLVERR;
  endtask : apb
  // release the bus at once, then let n clocks pass
  task automatic idle(input int n);
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    repeat (n) @(posedge MCLK);
  endtask : idle
  // one slow oscillator tick, eight clocks, noting any watchdog pulse
  task automatic tick(output logic fired);
    fired = 1'h0;
    for (int i = 0; i < 8; i++) begin
      OSC_TICK <= (i < 4);
      @(posedge MCLK);
      fired = fired | DOG_RESET;
    end
  endtask : tick
  task automatic count_to_dog(input int exp);
    logic f;
    int n;
    f = 1'h0;
    n = 0;
    while (!f && n < 300) begin
      tick(f);
      n++;
    end
    check(32'(n), 32'(exp));
  endtask : count_to_dog
  initial begin
    repeat (100000) @(posedge MCLK);
    error_cnt++;
    stop_test();
  end
  initial begin
    logic f;
    repeat (10) @(posedge MCLK);
    SRST <= 1'h0;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) check(rd, rows[i].d);
      if (rows[i].n != 0) idle(rows[i].n);
    end
    // three ticks short of a period, restart, then a full period for select codes 0 to 2
    for (int s = 0; s < 3; s++) begin
      apb(1'h1, WA, 32'h18);
      apb(1'h1, WA, 32'h08 | s);
      idle(1);
      repeat (3) tick(f);
      CHIP_RESET <= (s == 1);
      WATCHDOG_KICK <= (s != 1);
      repeat (2) @(posedge MCLK);
      CHIP_RESET <= 1'h0;
      WATCHDOG_KICK <= 1'h0;
      count_to_dog(4 << s);
    end
    PIN_RESET_EVENT <= 1'h1;
    BROWNOUT_EVENT <= 1'h1;
    SCAN_RESET_EVENT <= 1'h1;
    @(posedge MCLK);
    PIN_RESET_EVENT <= 1'h0;
    BROWNOUT_EVENT <= 1'h0;
    SCAN_RESET_EVENT <= 1'h0;
    apb(1'h0, CA, 32'h0);
    check(rd, 32'h1F);
    apb(1'h1, wdg_pkg::IRQ_MASK_OFS, 32'h3);
    idle(1);
    check(IRQ, 1'h1);
    apb(1'h1, wdg_pkg::IRQ_MASK_OFS, 32'h0);
    idle(1);
    check(IRQ, 1'h0);
    apb(1'h1, wdg_pkg::IRQ_MASK_OFS, 32'h3);
    apb(1'h1, wdg_pkg::IRQ_STAT_OFS, 32'h3);
    idle(1);
    check(IRQ, 1'h0);
    // software clear of the cause flags, then an unmapped read
    apb(1'h1, CA, 32'h0);
    apb(1'h0, CA, 32'h0);
    check(rd, 32'h0);
    apb(1'h0, 12'h010, 32'h0);
    check(32'(err), 32'h1);
    check(rd, 32'h0);
    ALWAYS_ON_FUSE <= 1'h1;
    idle(1);
    apb(1'h1, WA, 32'h18);
    apb(1'h1, WA, 32'h00);
    apb(1'h0, WA, 32'h0);
    check(rd, 32'h08);
    idle(1);
    // fuse held: the timed disable must not stop the count
    count_to_dog(4);
    SRST <= 1'h1;
    repeat (2) @(posedge MCLK);
    SRST <= 1'h0;
    apb(1'h0, CA, 32'h0);
    check(rd, 32'h01);
    idle(1);
    stop_test();
  end
endmodule : wdg_top_bench
`default_nettype wire
